//--- rtl/cpu_arith_branch_exec.sv
// Register access over APB and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - increment/decrement one cycle with z,n,v; negate is zero minus reg with c,h
// - or-mask and and-not-mask, one cycle, z,n,v updated
// - test keeps register, one cycle, z,n,v updated
// - clear gives zero with z,n,v; set loads all ones, flags kept
// - three multiplies write 16-bit product pair, two cycles, z and c
// - fractional multiplies shift product left one, two cycles, z and c
// - relative jump/call pc+k+1 in 2/3; direct jump/call pc=k in 3/4
// - pointer jump loads pc from z pair, two cycles, flags kept
// - pointer call three cycles; returns pop pc in four; irq return sets i
// - compare-skip-equal skips next when equal, 1/2/3 cycles, no flags
// - three compares subtract without storing, one cycle, six flags
// - register bit skips on clear or set bit, 1/2/3 cycles, no flags
// - i/o bit skips on clear or set bit, 1/2/3 cycles, no flags
// - flag branches pc+k+1 when bit matches, 1 cycle or 2 taken
// - i/o bit skips reach only addresses 0 to 0x1f
module cpu_arith_branch_exec import exec_pkg::*; #(
	parameter int unsigned STACK_DEPTH = 16
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// apb slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// low i/o space, same clock
	output logic [4:0] io_addr_o,
	input wire logic [7:0] io_rdata_i,
	// core status
	output logic busy_o
);
	localparam int unsigned SPW = $clog2(STACK_DEPTH);

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_EXEC = 3'b010,
		ST_HOLD = 3'b100
	} state_e;

	state_e state, next_state;
	instr_s ins, next_ins;
	logic [1:0] cnt, next_cnt;
	logic [15:0] pc, next_pc;
	logic [7:0] status_register, next_status_register;
	logic [7:0] gpr [32];
	logic [7:0] next_gpr [32];
	logic [15:0] stk [STACK_DEPTH];
	logic [15:0] next_stk [STACK_DEPTH];
	logic [SPW-1:0] sp, next_sp;
	logic [4:0] reg_sel, next_reg_sel;
	logic [4:0] next_io_addr;
	logic next_busy;
	logic [31:0] next_prdata;
	logic next_pready, next_pslverr;
	logic wr_ok;
	logic [7:0] rd, rr, res, alu_a, alu_b;
	logic alu_cin, wr_d, wr_pair, push, pop, commit, test_bit;
	alu_s alu;
	logic [15:0] prod, ex_pc, ret_pc, skip_pc, zptr;
	logic prod_c, a_sgn, b_sgn, frac;
	logic [7:0] ex_status_register;
	logic [2:0] ex_cyc, skip_cyc;

	// zero, negative, overflow and sign in one place
	function automatic logic [7:0] znv(input logic [7:0] s, input logic [7:0] r, input logic v);
		logic [7:0] o;
		o = s;
		o[FLAG_Z] = (r == ZERO_BYTE);
		o[FLAG_N] = r[7];
		o[FLAG_V] = v;
		o[FLAG_S] = r[7] ^ v;
		return o;
	endfunction

	// subtract flags; with carry-in, zero can only stay or clear
	function automatic logic [7:0] sub_flags(input logic [7:0] s, input alu_s a, input logic zk);
		logic [7:0] o;
		o = znv(s, a.res, a.v);
		o[FLAG_C] = a.c;
		o[FLAG_H] = a.h;
		o[FLAG_Z] = o[FLAG_Z] & (~zk | s[FLAG_Z]);
		return o;
	endfunction

	function automatic logic is_mapped(input logic [7:0] a);
		return a inside {ADDR_INSTR, ADDR_OPERAND, ADDR_PC, ADDR_STATUS,
			ADDR_REG_SEL, ADDR_REG_DATA, ADDR_STATE};
	endfunction

	// only the selector may move while an instruction runs
	function automatic logic refused(input logic [7:0] a, input logic w, input logic b);
		return ~is_mapped(a) | (w & (a == ADDR_STATE)) | (w & b & (a != ADDR_REG_SEL));
	endfunction

	assign rd = gpr[ins.d];
	assign rr = gpr[ins.r];
	assign zptr = {gpr[31], gpr[30]};
	assign wr_ok = psel_i & penable_i & pready_o & pwrite_i & ~pslverr_o;

	byte_sub u_sub (
		.a_i(alu_a),
		.b_i(alu_b),
		.cin_i(alu_cin),
		.out_o(alu)
	);

	product_unit u_prod (
		.a_i(rd),
		.b_i(rr),
		.a_signed_i(a_sgn),
		.b_signed_i(b_sgn),
		.frac_i(frac),
		.prod_o(prod),
		.carry_o(prod_c)
	);

	// operand steering for subtractor and multiplier
	always_comb begin
		alu_a = rd;
		alu_b = rr;
		alu_cin = 1'b0;
		a_sgn = ins.op inside {signed_product_op, mixed_sign_product_op,
			frac_signed_product_op, frac_mixed_product_op};
		b_sgn = ins.op inside {signed_product_op, frac_signed_product_op};
		frac = ins.op inside {frac_unsigned_product_op, frac_signed_product_op,
			frac_mixed_product_op};
		case (ins.op)
			negate_op: begin
				alu_a = ZERO_BYTE;
				alu_b = rd;
			end
			compare_carry_op: alu_cin = status_register[FLAG_C];
			compare_immediate_op: alu_b = ins.k[7:0];
			default: alu_cin = 1'b0;
		endcase
	end

	// execution: result, flags, next pc and cycle count
	always_comb begin
		res = rd;
		wr_d = 1'b0;
		wr_pair = 1'b0;
		push = 1'b0;
		pop = 1'b0;
		ex_status_register = status_register;
		ex_pc = pc + ONE_WORD;
		ex_cyc = CYC_BASIC;
		ret_pc = pc + ONE_WORD;
		test_bit = 1'b0;
		skip_pc = pc + (ins.two_word ? SKIP_LONG : SKIP_SHORT);
		skip_cyc = ins.two_word ? CYC_SKIP_LONG : CYC_SKIP_SHORT;
		case (ins.op)
			negate_op: begin
				res = alu.res;
				wr_d = 1'b1;
				ex_status_register = sub_flags(status_register, alu, 1'b0);
			end
			increment_op: begin
				res = rd + 8'h01;
				wr_d = 1'b1;
				ex_status_register = znv(status_register, res, rd == DEC_OVF);
			end
			decrement_op: begin
				res = rd - 8'h01;
				wr_d = 1'b1;
				ex_status_register = znv(status_register, res, rd == INC_OVF);
			end
			or_mask_op: begin
				res = rd | ins.k[7:0];
				wr_d = 1'b1;
				ex_status_register = znv(status_register, res, 1'b0);
			end
			and_not_mask_op: begin
				res = rd & (ALL_ONES - ins.k[7:0]);
				wr_d = 1'b1;
				ex_status_register = znv(status_register, res, 1'b0);
			end
			zero_sign_test_op: begin
				res = rd & rd;
				ex_status_register = znv(status_register, res, 1'b0);
			end
			zero_register_op: begin
				res = rd ^ rd;
				wr_d = 1'b1;
				ex_status_register = znv(status_register, res, 1'b0);
			end
			all_ones_register_op: begin
				res = ALL_ONES;
				wr_d = 1'b1;
			end
			unsigned_product_op, signed_product_op, mixed_sign_product_op,
			frac_unsigned_product_op, frac_signed_product_op, frac_mixed_product_op: begin
				wr_pair = 1'b1;
				ex_cyc = CYC_MUL;
				ex_status_register[FLAG_Z] = (prod == 16'h0000);
				ex_status_register[FLAG_C] = prod_c;
			end
			relative_jump_op: begin
				ex_pc = pc + ins.k + ONE_WORD;
				ex_cyc = CYC_RELATIVE_JUMP_OP;
			end
			pointer_jump_op: begin
				ex_pc = zptr;
				ex_cyc = CYC_POINTER_JUMP_OP;
			end
			absolute_jump_op: begin
				ex_pc = ins.k;
				ex_cyc = CYC_JMP;
			end
			relative_call_op: begin
				ex_pc = pc + ins.k + ONE_WORD;
				ex_cyc = CYC_RELATIVE_CALL_OP;
				push = 1'b1;
			end
			pointer_call_op: begin
				ex_pc = zptr;
				ex_cyc = CYC_POINTER_CALL_OP;
				push = 1'b1;
			end
			absolute_call_op: begin
				ex_pc = ins.k;
				ex_cyc = CYC_CALL;
				ret_pc = pc + SKIP_SHORT;
				push = 1'b1;
			end
			subroutine_return_op, irq_return_op: begin
				ex_pc = stk[sp - SPW'(1)];
				ex_cyc = CYC_RET;
				pop = 1'b1;
				if (ins.op == irq_return_op) begin
					ex_status_register[FLAG_I] = 1'b1;
				end
			end
			compare_skip_equal_op: test_bit = (rd == rr);
			compare_op, compare_carry_op, compare_immediate_op: begin
				ex_status_register = sub_flags(status_register, alu, ins.op == compare_carry_op);
			end
			skip_reg_bit_clear_op: test_bit = ~rr[ins.bsel];
			skip_reg_bit_set_op: test_bit = rr[ins.bsel];
			skip_io_bit_clear_op: test_bit = ~io_rdata_i[ins.bsel];
			skip_io_bit_set_op: test_bit = io_rdata_i[ins.bsel];
			branch_flag_set_op, branch_flag_clear_op: begin
				if (status_register[ins.bsel] == (ins.op == branch_flag_set_op)) begin
					ex_pc = pc + ins.k + ONE_WORD;
					ex_cyc = CYC_BR_TAKEN;
				end
			end
			default: res = rd;
		endcase
		// every skip form shares the same advance and timing
		if (test_bit) begin
			ex_pc = skip_pc;
			ex_cyc = skip_cyc;
		end
	end

	// commit on the last cycle; operands are frozen while busy
	assign commit = ((state == ST_EXEC) && (ex_cyc == CYC_BASIC)) ||
		((state == ST_HOLD) && (cnt == 2'h1));

	// core state: sequencer, program counter, flags, registers, stack
	always_comb begin
		next_state = state;
		next_ins = ins;
		next_cnt = cnt;
		next_pc = pc;
		next_status_register = status_register;
		next_gpr = gpr;
		next_stk = stk;
		next_sp = sp;
		next_io_addr = io_addr_o;
		unique case (state)
			ST_IDLE: begin
				if (wr_ok) begin
					case (paddr_i)
						ADDR_INSTR: begin
							next_ins.op = op_e'(pwdata_i[F_OP_LSB +: 5]);
							next_ins.d = pwdata_i[F_D_LSB +: 5];
							next_ins.r = pwdata_i[F_R_LSB +: 5];
							next_ins.bsel = pwdata_i[F_B_LSB +: 3];
							// the port field is five bits, so only 0..0x1f is reachable
							next_io_addr = pwdata_i[F_D_LSB +: 5] & IO_BIT_LIMIT;
							next_state = ST_EXEC;
						end
						ADDR_OPERAND: begin
							next_ins.k = pwdata_i[F_K_LSB +: 16];
							next_ins.two_word = pwdata_i[F_TWO_BIT];
						end
						ADDR_PC: next_pc = pwdata_i[15:0];
						ADDR_STATUS: next_status_register = pwdata_i[7:0];
						ADDR_REG_DATA: next_gpr[reg_sel] = pwdata_i[7:0];
						default: next_state = ST_IDLE;
					endcase
				end
			end
			ST_EXEC: begin
				next_cnt = 2'(ex_cyc - CYC_BASIC);
				next_state = commit ? ST_IDLE : ST_HOLD;
			end
			ST_HOLD: begin
				next_cnt = cnt - 2'h1;
				if (commit) begin
					next_state = ST_IDLE;
				end
			end
		endcase
		if (commit) begin
			next_pc = ex_pc;
			next_status_register = ex_status_register;
			if (wr_d) begin
				next_gpr[ins.d] = res;
			end
			if (wr_pair) begin
				next_gpr[1] = prod[15:8];
				next_gpr[0] = prod[7:0];
			end
			if (push) begin
				next_stk[sp] = ret_pc;
				next_sp = sp + SPW'(1);
			end
			if (pop) begin
				next_sp = sp - SPW'(1);
			end
		end
		next_busy = (next_state != ST_IDLE);
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state <= ST_IDLE;
			ins <= '0;
			cnt <= 2'h0;
			pc <= PC_RST;
			status_register <= STATUS_RST;
			gpr <= '{default: ZERO_BYTE};
			stk <= '{default: 16'h0000};
			sp <= '0;
			io_addr_o <= 5'h00;
			busy_o <= 1'b0;
		end else begin
			state <= next_state;
			ins <= next_ins;
			cnt <= next_cnt;
			pc <= next_pc;
			status_register <= next_status_register;
			gpr <= next_gpr;
			stk <= next_stk;
			sp <= next_sp;
			io_addr_o <= next_io_addr;
			busy_o <= next_busy;
		end
	end

	// apb: one wait state, read data and error latched with ready
	always_comb begin
		next_pready = psel_i & penable_i & ~pready_o;
		next_prdata = prdata_o;
		next_pslverr = 1'b0;
		next_reg_sel = reg_sel;
		if (wr_ok && (paddr_i == ADDR_REG_SEL)) begin
			next_reg_sel = pwdata_i[4:0];
		end
		if (next_pready) begin
			next_pslverr = refused(paddr_i, pwrite_i, busy_o);
			next_prdata = 32'h0000_0000;
			if (!pwrite_i) begin
				case (paddr_i)
					ADDR_INSTR: begin
						next_prdata[F_OP_LSB +: 5] = ins.op;
						next_prdata[F_D_LSB +: 5] = ins.d;
						next_prdata[F_R_LSB +: 5] = ins.r;
						next_prdata[F_B_LSB +: 3] = ins.bsel;
					end
					ADDR_OPERAND: begin
						next_prdata[F_K_LSB +: 16] = ins.k;
						next_prdata[F_TWO_BIT] = ins.two_word;
					end
					ADDR_PC: next_prdata[15:0] = pc;
					ADDR_STATUS: next_prdata[7:0] = status_register;
					ADDR_REG_SEL: next_prdata[4:0] = reg_sel;
					ADDR_REG_DATA: next_prdata[7:0] = gpr[reg_sel];
					ADDR_STATE: begin
						next_prdata[F_BUSY_BIT] = busy_o;
						next_prdata[F_SP_LSB +: SPW] = sp;
					end
					default: next_prdata = 32'h0000_0000;
				endcase
			end
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			prdata_o <= 32'h0000_0000;
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
			reg_sel <= 5'h00;
		end else begin
			prdata_o <= next_prdata;
			pready_o <= next_pready;
			pslverr_o <= next_pslverr;
			reg_sel <= next_reg_sel;
		end
	end
endmodule
`default_nettype wire

//--- rtl/exec_pkg.sv
`default_nettype none
package exec_pkg;
	// register byte addresses on the apb side
	localparam logic [7:0] ADDR_INSTR = 8'h00;
	localparam logic [7:0] ADDR_OPERAND = 8'h04;
	localparam logic [7:0] ADDR_PC = 8'h08;
	localparam logic [7:0] ADDR_STATUS = 8'h0c;
	localparam logic [7:0] ADDR_REG_SEL = 8'h10;
	localparam logic [7:0] ADDR_REG_DATA = 8'h14;
	localparam logic [7:0] ADDR_STATE = 8'h18;
	// field positions in the instruction, operand and state words
	localparam int unsigned F_OP_LSB = 0;
	localparam int unsigned F_D_LSB = 5;
	localparam int unsigned F_R_LSB = 10;
	localparam int unsigned F_B_LSB = 15;
	localparam int unsigned F_K_LSB = 0;
	localparam int unsigned F_TWO_BIT = 16;
	localparam int unsigned F_BUSY_BIT = 0;
	localparam int unsigned F_SP_LSB = 8;
	// status register bit positions
	localparam int unsigned FLAG_C = 0;
	localparam int unsigned FLAG_Z = 1;
	localparam int unsigned FLAG_N = 2;
	localparam int unsigned FLAG_V = 3;
	localparam int unsigned FLAG_S = 4;
	localparam int unsigned FLAG_H = 5;
	localparam int unsigned FLAG_I = 7;
	// constants and reset values
	localparam logic [7:0] ZERO_BYTE = 8'h00;
	localparam logic [7:0] ALL_ONES = 8'hff;
	localparam logic [7:0] INC_OVF = 8'h80;
	localparam logic [7:0] DEC_OVF = 8'h7f;
	localparam logic [4:0] IO_BIT_LIMIT = 5'h1f;
	localparam logic [15:0] PC_RST = 16'h0000;
	localparam logic [7:0] STATUS_RST = 8'h00;
	localparam logic [15:0] ONE_WORD = 16'h0001;
	localparam logic [15:0] SKIP_SHORT = 16'h0002;
	localparam logic [15:0] SKIP_LONG = 16'h0003;
	// cycle counts
	localparam logic [2:0] CYC_BASIC = 3'h1;
	localparam logic [2:0] CYC_MUL = 3'h2;
	localparam logic [2:0] CYC_RELATIVE_JUMP_OP = 3'h2;
	localparam logic [2:0] CYC_POINTER_JUMP_OP = 3'h2;
	localparam logic [2:0] CYC_JMP = 3'h3;
	localparam logic [2:0] CYC_RELATIVE_CALL_OP = 3'h3;
	localparam logic [2:0] CYC_POINTER_CALL_OP = 3'h3;
	localparam logic [2:0] CYC_CALL = 3'h4;
	localparam logic [2:0] CYC_RET = 3'h4;
	localparam logic [2:0] CYC_BR_TAKEN = 3'h2;
	localparam logic [2:0] CYC_SKIP_SHORT = 3'h2;
	localparam logic [2:0] CYC_SKIP_LONG = 3'h3;

	typedef enum logic [4:0] {
		negate_op, increment_op, decrement_op, or_mask_op,
		and_not_mask_op, zero_sign_test_op, zero_register_op, all_ones_register_op,
		unsigned_product_op, signed_product_op, mixed_sign_product_op,
		frac_unsigned_product_op, frac_signed_product_op, frac_mixed_product_op,
		relative_jump_op, pointer_jump_op, absolute_jump_op, relative_call_op,
		pointer_call_op, absolute_call_op, subroutine_return_op, irq_return_op,
		compare_skip_equal_op, compare_op, compare_carry_op, compare_immediate_op,
		skip_reg_bit_clear_op, skip_reg_bit_set_op, skip_io_bit_clear_op,
		skip_io_bit_set_op, branch_flag_set_op, branch_flag_clear_op
	} op_e;

	typedef struct packed {
		op_e op;
		logic [4:0] d;
		logic [4:0] r;
		logic [2:0] bsel;
		logic [15:0] k;
		logic two_word;
	} instr_s;

	typedef struct packed {
		logic [7:0] res;
		logic c;
		logic h;
		logic v;
	} alu_s;
endpackage
`default_nettype wire

//--- rtl/byte_sub.sv
`timescale 1ns/1ps
`default_nettype none
module byte_sub import exec_pkg::*; (
	// operands
	input wire logic [7:0] a_i,
	input wire logic [7:0] b_i,
	input wire logic cin_i,
	// difference and flags
	output var alu_s out_o
);
	logic [8:0] diff;
	logic [7:0] r;

	// nine-bit difference keeps the borrow
	assign diff = {1'b0, a_i} - {1'b0, b_i} - {8'h00, cin_i};
	assign r = diff[7:0];
	assign out_o.res = r;
	assign out_o.c = diff[8];
	// borrow out of bit 3 and signed overflow
	assign out_o.h = (~a_i[3] & b_i[3]) | (b_i[3] & r[3]) | (r[3] & ~a_i[3]);
	assign out_o.v = (a_i[7] & ~b_i[7] & ~r[7]) | (~a_i[7] & b_i[7] & r[7]);
endmodule
`default_nettype wire

//--- rtl/product_unit.sv
`timescale 1ns/1ps
`default_nettype none
module product_unit (
	// factors and their signedness
	input wire logic [7:0] a_i,
	input wire logic [7:0] b_i,
	input wire logic a_signed_i,
	input wire logic b_signed_i,
	input wire logic frac_i,
	// product
	output logic [15:0] prod_o,
	output logic carry_o
);
	logic signed [8:0] ax;
	logic signed [8:0] bx;
	logic signed [17:0] p;

	// a ninth bit extends each factor as signed or unsigned
	assign ax = $signed({a_signed_i & a_i[7], a_i});
	assign bx = $signed({b_signed_i & b_i[7], b_i});
	assign p = ax * bx;
	// carry is the top product bit before the fractional shift
	assign carry_o = p[15];
	assign prod_o = frac_i ? {p[14:0], 1'b0} : p[15:0];
endmodule
`default_nettype wire

//--- dv/io_space_model.sv
`timescale 1ns/1ps
`default_nettype none
module io_space_model (
	// address from the core
	input wire logic [4:0] io_addr_i,
	// per-run byte pattern chosen by the bench
	input wire logic [7:0] pattern_i,
	// read data, same clock, combinational
	output logic [7:0] io_rdata_o
);
	// only the bit-addressable low range exists; each address reads its own byte
	assign io_rdata_o = {io_addr_i, 3'h5} ^ pattern_i;
endmodule
`default_nettype wire

//--- dv/cpu_arith_branch_exec_checker.sv
`timescale 1ns/1ps
`default_nettype none
module cpu_arith_branch_exec_checker import exec_pkg::*; (
	// clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// apb
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [7:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [31:0] prdata_o,
	input wire logic pready_o,
	input wire logic pslverr_o,
	// i/o and status
	input wire logic [4:0] io_addr_o,
	input wire logic [7:0] io_rdata_i,
	input wire logic busy_o
);
	logic go;
	logic [4:0] go_op;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	// accepted instruction write and its op field
	assign go = psel_i && penable_i && pready_o && !pslverr_o && pwrite_i && paddr_i == ADDR_INSTR;
	assign go_op = pwdata_i[4:0];
	a_one_wait: assert property ((psel_i && !penable_i) ##1 (psel_i && penable_i) |=> pready_o)
		else $error("pready late");
	a_ready_pulse: assert property (pready_o |=> !pready_o) else $error("pready too long");
	a_err_with_ready: assert property (pslverr_o |-> pready_o) else $error("lone pslverr");
	a_unmapped_refused: assert property (psel_i && penable_i && !pready_o && paddr_i > ADDR_STATE
		|=> pslverr_o) else $error("unmapped accepted");
	a_simple_op_cycles: assert property (go
		&& go_op <= 5'h07 |=> busy_o ##1 !busy_o) else $error("simple op length");
	a_product_cycles: assert property (go
		&& go_op inside {[unsigned_product_op:frac_mixed_product_op]}
		|=> busy_o [*2] ##1 !busy_o) else $error("product length");
	a_jump_two_cycles: assert property (go
		&& go_op inside {relative_jump_op, pointer_jump_op}
		|=> busy_o [*2] ##1 !busy_o) else $error("jump length");
	a_call_ret_cycles: assert property (go
		&& go_op inside {absolute_call_op, subroutine_return_op, irq_return_op}
		|=> busy_o [*4] ##1 !busy_o) else $error("call or return length");
	a_compare_cycles: assert property (go
		&& go_op inside {[compare_op:compare_immediate_op]}
		|=> busy_o ##1 !busy_o) else $error("compare length");
	a_skip_bound: assert property (go
		&& go_op inside {compare_skip_equal_op, [skip_reg_bit_clear_op:skip_io_bit_set_op]}
		|=> busy_o ##[1:3] !busy_o) else $error("skip length");
	a_branch_bound: assert property (go && go_op >= 5'h1e |=> busy_o ##[1:2] !busy_o)
		else $error("branch length");
	a_io_addr_held: assert property (busy_o && $past(busy_o) |-> $stable(io_addr_o))
		else $error("io address moved");
	// main scenarios reached
	c_call: cover property (go && go_op == absolute_call_op);
	c_io_skip: cover property (go && go_op == skip_io_bit_set_op);
	c_refused: cover property (pslverr_o);
endmodule
bind cpu_arith_branch_exec cpu_arith_branch_exec_checker chk_i (.clk_i(clk_i), .nrst_i(nrst_i),
	.psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
	.pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
	.io_addr_o(io_addr_o), .io_rdata_i(io_rdata_i), .busy_o(busy_o));
`default_nettype wire

//--- dv/test_cpu_arith_branch_exec.sv
`timescale 1ns/1ps
`default_nettype none
module test_cpu_arith_branch_exec import exec_pkg::*; ;
	logic clk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic psel_i = 1'b0;
	logic penable_i = 1'b0;
	logic pwrite_i = 1'b0;
	logic [7:0] paddr_i = 8'h00;
	logic [31:0] pwdata_i = 32'h0;
	logic [7:0] pattern = 8'h00;
	logic [31:0] prdata_o, rd;
	logic pready_o, pslverr_o, busy_o, err, tw, tk;
	logic [4:0] io_addr_o, d, r;
	logic [7:0] io_rdata_i, st, a, b, io8;
	logic [7:0] gpr [32];
	logic [15:0] rnd = 16'h0033;
	logic [15:0] pc, w, z, e16, x16, sk;
	logic [17:0] m;
	logic [15:0] stk [$];
	logic [2:0] bs;
	op_e op;
	int cy;
	int jc [6] = '{2, 2, 3, 3, 3, 4};
	int mismatches = 0;
	int samples_checked = 0;
	always #10 clk_i = ~clk_i;
	cpu_arith_branch_exec uut (.clk_i(clk_i), .nrst_i(nrst_i), .psel_i(psel_i),
		.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
		.prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
		.io_addr_o(io_addr_o), .io_rdata_i(io_rdata_i), .busy_o(busy_o));
	io_space_model far (.io_addr_i(io_addr_o), .pattern_i(pattern), .io_rdata_o(io_rdata_i));
	function automatic logic [15:0] nx();
		rnd = {rnd[14:0], rnd[15] ^ rnd[13] ^ rnd[12] ^ rnd[10]};
		return rnd;
	endfunction
	// expected stored byte and status of the one-cycle ops
	function automatic logic [15:0] alu(input op_e o, input logic [7:0] x, y, s);
		logic [8:0] t;
		logic [4:0] hn;
		logic [7:0] p, q, f;
		logic c, sb;
		f = s;
		sb = o inside {negate_op, compare_op, compare_carry_op, compare_immediate_op};
		p = (o == negate_op) ? 8'h00 : x;
		q = (o == negate_op) ? x : y;
		c = (o == compare_carry_op) ? s[FLAG_C] : 1'b0;
		t = {1'b0, p} - {1'b0, q} - {8'h00, c};
		hn = {1'b0, p[3:0]} - {1'b0, q[3:0]} - {4'h0, c};
		f[FLAG_V] = (p[7] & ~q[7] & ~t[7]) | (~p[7] & q[7] & t[7]);
		if (!sb) f[FLAG_V] = (o == increment_op && x == 8'h7f) || (o == decrement_op && x == 8'h80);
		case (o)
			increment_op: t[7:0] = x + 8'h01;
			decrement_op: t[7:0] = x - 8'h01;
			or_mask_op: t[7:0] = x | y;
			and_not_mask_op: t[7:0] = x & (8'hff - y);
			zero_sign_test_op: t[7:0] = x;
			zero_register_op: t[7:0] = 8'h00;
			all_ones_register_op: return {8'hff, s};
			default: t = t;
		endcase
		f[FLAG_Z] = (t[7:0] == 8'h00) && (o != compare_carry_op || s[FLAG_Z]);
		f[FLAG_N] = t[7];
		if (sb) f[FLAG_C] = t[8];
		if (sb) f[FLAG_H] = hn[4];
		return {(sb && o != negate_op) ? x : t[7:0], f};
	endfunction
	// expected product, carry before the shift, zero after it
	function automatic logic [17:0] mulx(input op_e o, input logic [7:0] x, y);
		logic sa, sy, c;
		logic [15:0] p;
		sa = !(o == unsigned_product_op || o == frac_unsigned_product_op);
		sy = (o == signed_product_op || o == frac_signed_product_op);
		p = $signed({sa & x[7], x}) * $signed({sy & y[7], y});
		c = p[15];
		if (o >= frac_unsigned_product_op) p = p << 1;
		return {p, c, p == 16'h0000};
	endfunction
	task automatic chk(input string nm, input logic [31:0] e, g);
		samples_checked++;
		if (g !== e) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic end_sim;
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// one apb transfer, held until pready is sampled high
	task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] dat);
		int n;
		n = 0;
		@(posedge clk_i);
		psel_i <= 1'b1;
		pwrite_i <= wr;
		paddr_i <= ad;
		pwdata_i <= dat;
		@(posedge clk_i);
		penable_i <= 1'b1;
		do begin
			@(posedge clk_i);
			n++;
		end while (pready_o !== 1'b1 && n < 16);
		rd = prdata_o;
		err = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
		if (n >= 16) chk("pready", 32'h1, 32'h0);
	endtask
	task automatic setr(input logic [4:0] i, input logic [7:0] v);
		apb(1'b1, ADDR_REG_SEL, {27'h0, i});
		apb(1'b1, ADDR_REG_DATA, {24'h0, v});
		gpr[i] = v;
	endtask
	task automatic getr(input logic [4:0] i);
		apb(1'b1, ADDR_REG_SEL, {27'h0, i});
		apb(1'b0, ADDR_REG_DATA, 32'h0);
		chk("gpr", {24'h0, gpr[i]}, rd);
	endtask
	task automatic pcchk(input logic [15:0] e);
		apb(1'b0, ADDR_PC, 32'h0);
		chk("pc", {16'h0, e}, rd);
	endtask
	// sign flag is left out: its update is not pinned down
	task automatic stchk(input logic [7:0] e);
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk("status", {24'h0, e & 8'hef}, rd & 32'hef);
	endtask
	// issue one instruction and count the cycles busy stays high
	task automatic exec(input op_e o, input logic [4:0] dd, rr, input logic [2:0] bb,
		input logic [15:0] k, input logic two, input int cyc);
		int n;
		apb(1'b1, ADDR_OPERAND, {15'h0, two, k});
		apb(1'b1, ADDR_INSTR, {14'h0, bb, rr, dd, o});
		#1;
		n = 0;
		while (busy_o === 1'b1 && n < 8) begin
			@(posedge clk_i);
			#1;
			n++;
		end
		chk("cycles", cyc, n);
	endtask
	initial begin
		repeat (60000) @(posedge clk_i);
		mismatches++;
		end_sim();
	end
	initial begin
		repeat (10) @(posedge clk_i);
		nrst_i <= 1'b1;
		pcchk(PC_RST);
		stchk(STATUS_RST);
		apb(1'b0, 8'h1c, 32'h0);
		chk("unmapped", 32'h1, rd | {31'h0, err});
		apb(1'b1, ADDR_STATE, 32'h1);
		chk("state write", 32'h1, {31'h0, err});
		for (int i = 0; i < 44; i++) begin
			op = op_e'((i % 11 < 8) ? i % 11 : 15 + i % 11);
			e16 = nx();
			w = nx();
			z = nx();
			d = e16[4:0];
			setr(e16[9:5], w[15:8]);
			setr(d, (i >= 33) ? (i[0] ? 8'h80 : 8'h7f) : w[7:0]);
			apb(1'b1, ADDR_STATUS, {24'h0, z[7:0]});
			b = op inside {or_mask_op, and_not_mask_op, compare_immediate_op} ? z[15:8] : gpr[e16[9:5]];
			x16 = alu(op, gpr[d], b, z[7:0]);
			exec(op, d, e16[9:5], 3'h0, {8'h00, z[15:8]}, 1'b0, 1);
			gpr[d] = x16[15:8];
			getr(d);
			stchk(x16[7:0]);
		end
		for (int i = 0; i < 24; i++) begin
			op = op_e'(8 + i % 6);
			e16 = nx();
			w = (i < 6) ? 16'h8080 : nx();
			z = nx();
			setr(e16[9:5], w[15:8]);
			setr(e16[4:0], w[7:0]);
			apb(1'b1, ADDR_STATUS, {24'h0, z[7:0]});
			m = mulx(op, gpr[e16[4:0]], gpr[e16[9:5]]);
			exec(op, e16[4:0], e16[9:5], 3'h0, 16'h0000, 1'b0, 2);
			gpr[1] = m[17:10];
			gpr[0] = m[9:2];
			getr(5'h00);
			getr(5'h01);
			st = z[7:0];
			st[FLAG_C] = m[1];
			st[FLAG_Z] = m[0];
			stchk(st);
		end
		apb(1'b1, ADDR_STATUS, 32'h0);
		for (int i = 0; i < 6; i++) begin
			op = op_e'(14 + i);
			z = nx();
			w = nx();
			e16 = nx();
			apb(1'b1, ADDR_PC, {16'h0, z});
			pc = z;
			setr(5'h1e, w[7:0]);
			setr(5'h1f, w[15:8]);
			case (op)
				relative_jump_op, relative_call_op: x16 = pc + e16 + 16'h0001;
				pointer_jump_op, pointer_call_op: x16 = w;
				default: x16 = e16;
			endcase
			if (op >= relative_call_op) stk.push_back(pc + ((op == absolute_call_op) ? 16'h2 : 16'h1));
			exec(op, 5'h00, 5'h00, 3'h0, e16, 1'b0, jc[i]);
			pcchk(x16);
			stchk(8'h00);
		end
		for (int j = 0; j < 3; j++) begin
			op = (j == 0) ? irq_return_op : subroutine_return_op;
			exec(op, 5'h00, 5'h00, 3'h0, 16'h0, 1'b0, 4);
			pcchk(stk.pop_back());
		end
		stchk(8'h80);
		e16 = nx();
		apb(1'b1, ADDR_OPERAND, {16'h0, e16});
		apb(1'b1, ADDR_INSTR, {27'h0, absolute_call_op});
		apb(1'b1, ADDR_PC, 32'h0);
		chk("busy refusal", 32'h1, {31'h0, err});
		for (int n = 0; n < 8 && busy_o === 1'b1; n++) @(posedge clk_i);
		pcchk(e16);
		for (int i = 0; i < 42; i++) begin
			op = op_e'((i % 7 == 0) ? 22 : 25 + i % 7);
			z = nx();
			w = nx();
			e16 = nx();
			apb(1'b1, ADDR_PC, {16'h0, z});
			pc = z;
			st = z[15:8];
			apb(1'b1, ADDR_STATUS, {24'h0, st});
			d = e16[4:0];
			r = (op == compare_skip_equal_op) ? e16[9:5] : d;
			bs = e16[12:10];
			tw = e16[13] && op < branch_flag_set_op;
			setr(r, w[15:8]);
			setr(d, e16[15] ? w[15:8] : w[7:0]);
			pattern <= w[7:0];
			io8 = {d, 3'h5} ^ w[7:0];
			case (op)
				compare_skip_equal_op: tk = (gpr[d] == gpr[r]);
				skip_reg_bit_clear_op: tk = !gpr[d][bs];
				skip_reg_bit_set_op: tk = gpr[d][bs];
				skip_io_bit_clear_op: tk = !io8[bs];
				skip_io_bit_set_op: tk = io8[bs];
				branch_flag_set_op: tk = st[bs];
				default: tk = !st[bs];
			endcase
			sk = (op >= branch_flag_set_op) ? w + 16'h0001 : (tw ? SKIP_LONG : SKIP_SHORT);
			cy = tk ? ((op >= branch_flag_set_op) ? 2 : 2 + int'(tw)) : 1;
			exec(op, d, r, bs, w, tw, cy);
			pcchk(tk ? pc + sk : pc + ONE_WORD);
			stchk(st);
		end
		end_sim();
	end
endmodule
`default_nettype wire
